// ===== dv/brf_chk.sv
/*
  Checker on the read-port pins, pointers and interrupt.
  Assumes it is bound to brf_read_port and sees only its ports.
*/
module brf_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       a_byte_output_enable_n,
  input wire logic       port16_select,
  input wire logic       fifo_mode,
  input wire logic [2:0] depth_threshold,
  input wire logic       pointer_increment_write,
  input wire logic       pointer_reset_write,
  input wire logic       sample_valid,
  input wire logic [7:0] a_output_byte,
  input wire logic [7:0] b_output_byte,
  input wire logic       threshold_interrupt_n,
  input wire logic [2:0] buffer_depth,
  input wire logic [2:0] write_pointer,
  input wire logic [2:0] read_pointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ========================================================================
  // Pointers
  a_ptr_distinct: assert property (
    write_pointer != read_pointer) else $error("pointers equal");
  a_depth_mod: assert property (
    buffer_depth == 3'(write_pointer - read_pointer))
    else $error("depth wrong");
  a_reset_init: assert property (disable iff (1'b0)
    reset |=> write_pointer == 3'h0 && read_pointer == 3'h7)
    else $error("reset pointers wrong");
  a_clear_word: assert property (
    pointer_reset_write |=> write_pointer == 3'h0 && read_pointer == 3'h7)
    else $error("pointer reset wrong");
  a_full_drop: assert property (
    buffer_depth == 3'h7 && !pointer_reset_write |=> $stable(write_pointer))
    else $error("write while full");
  a_empty_hold: assert property (
    buffer_depth == 3'h1 && !pointer_reset_write |=> $stable(read_pointer))
    else $error("increment while empty");
  a_cpu_step: assert property (
    pointer_increment_write && !port16_select && buffer_depth != 3'h1 &&
    !pointer_reset_write |=> read_pointer == $past(read_pointer) + 3'h1)
    else $error("increment word missed");

  // ========================================================================
  // Interrupt and bytes
  a_irq_width: assert property (
    $fell(threshold_interrupt_n) |->
    !threshold_interrupt_n [*8] ##1 threshold_interrupt_n)
    else $error("interrupt width wrong");
  a_irq_cross: assert property (
    fifo_mode && $past(fifo_mode) && $past(threshold_interrupt_n) &&
    $rose(buffer_depth > depth_threshold) |-> !threshold_interrupt_n)
    else $error("interrupt missed");
  a_bytes_idle: assert property (
    a_byte_output_enable_n [*3] |=>
    a_output_byte == 8'h00 && b_output_byte == 8'h00)
    else $error("bytes driven while disabled");
  c_irq: cover property ($fell(threshold_interrupt_n));
  c_full: cover property (buffer_depth == 3'h7 && sample_valid);
  c_cpu: cover property (pointer_increment_write && !port16_select);
endmodule : brf_chk

bind brf_read_port brf_chk i_chk (
  .clk, .reset, .a_byte_output_enable_n, .port16_select, .fifo_mode,
  .depth_threshold, .pointer_increment_write, .pointer_reset_write,
  .sample_valid, .a_output_byte, .b_output_byte, .threshold_interrupt_n,
  .buffer_depth, .write_pointer, .read_pointer
);

// ===== dv/brf_host.sv
/*
  Model of the 16-bit reader on the select and output-enable pins.
  Assumes the caller enters rd16 just after a rising clock edge.
*/
module brf_host (
  input  wire logic       clk,
  input  wire logic [7:0] a_output_byte,
  input  wire logic [7:0] b_output_byte,
  output logic      [2:0] read_select,
  output logic            a_byte_output_enable_n,
  output logic            b_byte_output_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    read_select = 3'h0;
    a_byte_output_enable_n = 1'b1;
    b_byte_output_enable_n = 1'b1;
  end

  // ========================================================================
  // One read cycle, then release
  task automatic rd16(input logic [2:0] sel, output logic [15:0] word);
    read_select <= sel;
    a_byte_output_enable_n <= 1'b0;
    b_byte_output_enable_n <= 1'b0;
    repeat (5) @(posedge clk);
    word = {a_output_byte, b_output_byte};
    a_byte_output_enable_n <= 1'b1;
    b_byte_output_enable_n <= 1'b1;
    read_select <= ~sel;
    repeat (4) @(posedge clk);
  endtask : rd16
endmodule : brf_host

// ===== dv/brf_read_port_tb_top.sv
/*
  Self-checking bench of the buffer read port.
  Assumes brf_host and the bound checker are compiled before it.
*/
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  errors++; $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end

module brf_read_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        port16_select = 1'b1;
  logic        fifo_mode = 1'b1;
  logic [2:0]  depth_threshold = 3'h2;
  logic        pointer_increment_write = 1'b0;
  logic        pointer_reset_write = 1'b0;
  logic        snapshot_done = 1'b0;
  logic        sample_valid = 1'b0;
  logic [15:0] smp [0:4] = '{default: 16'h0000};
  logic [2:0]  cpu_read_select = 3'h0;
  logic [2:0]  read_select;
  logic        oea_n;
  logic        oeb_n;
  logic [7:0]  a_output_byte;
  logic [7:0]  b_output_byte;
  logic [15:0] cpu_read_data;
  logic        threshold_interrupt_n;
  logic        threshold_ready_n;
  logic [2:0]  buffer_depth;
  logic [2:0]  write_pointer;
  logic [2:0]  read_pointer;
  int          errors = 0;
  int          compares = 0;
  int          irq_lows = 0;

  always #10 clk = ~clk;
  always @(posedge clk) if (!reset && threshold_interrupt_n === 1'b0)
    irq_lows <= irq_lows + 1;

  brf_read_port i_dut (
    .clk, .reset, .read_select, .a_byte_output_enable_n(oea_n),
    .b_byte_output_enable_n(oeb_n), .port16_select, .fifo_mode,
    .depth_threshold, .pointer_increment_write, .pointer_reset_write,
    .snapshot_done, .sample_valid, .sample_i(smp[0]), .sample_q(smp[1]),
    .sample_magnitude(smp[2]), .sample_phase(smp[3]),
    .sample_frequency(smp[4]), .cpu_read_select, .a_output_byte,
    .b_output_byte, .cpu_read_data, .threshold_interrupt_n,
    .threshold_ready_n, .buffer_depth, .write_pointer, .read_pointer
  );
  brf_host i_host (
    .clk, .a_output_byte, .b_output_byte, .read_select,
    .a_byte_output_enable_n(oea_n), .b_byte_output_enable_n(oeb_n)
  );

  // ========================================================================
  // Helpers
  function automatic logic [15:0] wexp(input int s, input int k);
    return 16'((s + 1) * 4096 + k);
  endfunction : wexp

  task automatic put_set(input int k);
    for (int s = 0; s < 5; s++) smp[s] <= wexp(s, k);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(posedge clk);
  endtask : put_set

  task automatic pin_chk(input logic [2:0] s, input logic [15:0] exp);
    logic [15:0] w;
    i_host.rd16(s, w);
    `CHK(w, exp)
  endtask : pin_chk

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ========================================================================
  // Tests
  initial begin
    logic [15:0] w;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({write_pointer, read_pointer, buffer_depth}, 9'h039)
    pin_chk(3'h6, 16'h3400);
    i_host.rd16(3'h7, w);
    `CHK(read_pointer, 3'h7)
    for (int k = 0; k < 3; k++) put_set(k);
    repeat (12) @(posedge clk);
    `CHK(irq_lows, 8)
    i_host.rd16(3'h7, w);
    `CHK(read_pointer, 3'h0)
    repeat (4) @(posedge clk);
    for (int s = 0; s < 5; s++) pin_chk(3'(s), wexp(s, 0));
    pin_chk(3'h5, 16'h0000);
    `CHK(read_pointer, 3'h0)
    port16_select <= 1'b0;
    pointer_increment_write <= 1'b1;
    @(posedge clk);
    pointer_increment_write <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(read_pointer, 3'h1)
    for (int s = 0; s < 5; s++) begin
      cpu_read_select <= 3'(s);
      repeat (2) @(posedge clk);
      `CHK(cpu_read_data, wexp(s, 1))
    end
    port16_select <= 1'b1;
    for (int k = 3; k < 9; k++) put_set(k);
    `CHK({buffer_depth, write_pointer}, 6'h38)
    pin_chk(3'h6, 16'he800);
    `CHK(irq_lows, 16)
    pointer_reset_write <= 1'b1;
    @(posedge clk);
    pointer_reset_write <= 1'b0;
    @(posedge clk);
    `CHK({write_pointer, read_pointer}, 6'h07)
    fifo_mode <= 1'b0;
    snapshot_done <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK(threshold_ready_n, 1'b0)
    `CHK(irq_lows, 24)
    summarize();
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : brf_read_port_tb_top

// ===== src/brf_params.svh
/*
  Constants of the sample-buffer read port: select codes, status bit
  positions, sample-set field layout, pointer reset values and counts.
  Assumes inclusion by bare name from the package and from brf_read_port.
*/
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH

// ==========================================================================
// Select codes of the 16-bit read port
`define BRF_SEL_I          3'h0
`define BRF_SEL_Q          3'h1
`define BRF_SEL_MAG        3'h2
`define BRF_SEL_PHASE      3'h3
`define BRF_SEL_FREQ       3'h4
`define BRF_SEL_UNUSED     3'h5
`define BRF_SEL_STATUS     3'h6
`define BRF_SEL_INC        3'h7

// ==========================================================================
// Sample-set layout, low bit of each 16-bit word in the 80-bit entry
`define BRF_WORD_W         16
`define BRF_SET_W          80
`define BRF_I_LSB          64
`define BRF_Q_LSB          48
`define BRF_MAG_LSB        32
`define BRF_PHASE_LSB      16
`define BRF_FREQ_LSB       0

// ==========================================================================
// Memory status word, A byte bit positions (B byte reads zero)
`define BRF_ST_DEPTH_MSB   7
`define BRF_ST_DEPTH_LSB   5
`define BRF_ST_EMPTY_BIT   4
`define BRF_ST_FULL_BIT    3
`define BRF_ST_READY_BIT   2

// ==========================================================================
// Pointer reset values and thresholds
`define BRF_WR_PTR_RST     3'h0
`define BRF_RD_PTR_RST     3'h7
`define BRF_DEPTH_FULL     3'h7
`define BRF_DEPTH_EMPTY    3'h1

// ==========================================================================
// Timing counts in back-end clock cycles
`define BRF_IRQ_LOW_CYCLES 4'h8
`define BRF_INC_LATENCY    4'h4

`endif

// ===== src/brf_pkg.sv
/*
  Types of the sample-buffer read port: the register state of each module.
  Assumes brf_params.svh is on the include path.
*/
`include "brf_params.svh"

package brf_pkg;

  // ========================================================================
  // Top-level state
  typedef struct packed {
    logic [2:0]  wr_ptr;
    logic [2:0]  rd_ptr;
    logic        oeb_prev;
    logic        snap_prev;
    logic [15:0] word;
    logic [7:0]  a_out;
    logic [7:0]  b_out;
    logic        irq_n;
    logic [3:0]  irq_cnt;
    logic        ready_n;
    logic [15:0] cpu_data;
  } brf_state_type;

  // ========================================================================
  // Synchroniser state, five pin bits
  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
  } brf_sync_state_type;

  // ========================================================================
  // Sample memory read register
  typedef struct packed {
    logic [79:0] rd_data;
  } brf_ram_state_type;

endpackage : brf_pkg

// ===== src/brf_read_port.sv
/*
  Read side of the eight-entry output sample buffer: pointers, depth,
  full and empty, memory status word, 16-bit pin port, 8-bit port word,
  threshold ready and interrupt pulse.
  Assumes the sample write path and snapshot timer sit outside and that
  configuration bits arrive as levels and pulses on clk.
*/
// Notes on behaviour
// - Select 000 I, 001 Q, 010 magnitude, 011 phase, 100 frequency.
// - Both enables low: high byte on A, low byte on B.
// - Only the falling edge of the B enable starts an access.
// - Select 110 returns status; A bits 1-0 and B byte are zero.
// - In FIFO mode status bits 7-5 give the buffer depth.
// - Status bit 4 is empty, high when read pointer cannot move.
// - Status bit 3 is full, high when new samples are dropped.
// - Status bit 2 low: depth above the threshold, or snapshot captured.
// - With 8-bit port in use, increment word write advances read.
// - On 16-bit port, select 7 with B enable falling advances read.
// - Pointer reset word sets write pointer 0, read pointer 7.
// - Read and write pointers never hold the same address.
// - Full at depth seven; new samples dropped while full.
// - Empty at depth one; increments ignored while empty.
// - Reset sets write pointer 0 and read pointer 7.
// - Depth is write minus read, modulo eight.
// - Interrupt fires when depth rises past the threshold in FIFO mode, else on snapshot done rising.
// - Interrupt output stays low for eight clocks.
// - Each entry holds I, Q, magnitude, phase, frequency words.
`include "brf_params.svh"

module brf_read_port (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [2:0]  read_select,
  input  wire logic        a_byte_output_enable_n,
  input  wire logic        b_byte_output_enable_n,
  input  wire logic        port16_select,
  input  wire logic        fifo_mode,
  input  wire logic [2:0]  depth_threshold,
  input  wire logic        pointer_increment_write,
  input  wire logic        pointer_reset_write,
  input  wire logic        snapshot_done,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_i,
  input  wire logic [15:0] sample_q,
  input  wire logic [15:0] sample_magnitude,
  input  wire logic [15:0] sample_phase,
  input  wire logic [15:0] sample_frequency,
  input  wire logic [2:0]  cpu_read_select,
  output logic      [7:0]  a_output_byte,
  output logic      [7:0]  b_output_byte,
  output logic      [15:0] cpu_read_data,
  output logic             threshold_interrupt_n,
  output logic             threshold_ready_n,
  output logic      [2:0]  buffer_depth,
  output logic      [2:0]  write_pointer,
  output logic      [2:0]  read_pointer
);

  brf_pkg::brf_state_type st_r;
  brf_pkg::brf_state_type st_nxt;

  logic [4:0]  pins_sync;
  logic [2:0]  sel_s;
  logic        oea_n_s;
  logic        oeb_n_s;
  logic [79:0] set_data;
  logic [79:0] wr_set;
  logic [2:0]  depth;
  logic [2:0]  depth_after;
  logic        full;
  logic        empty;
  logic        oeb_fall;
  logic        inc_req;
  logic        do_inc;
  logic        do_wr;
  logic        above_now;
  logic        above_after;
  logic        irq_fire;
  logic [15:0] status_word;

  // ==========================================================================
  // Pin synchronisation
  brf_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({b_byte_output_enable_n, a_byte_output_enable_n,
                read_select}),
    .pin_sync (pins_sync)
  );

  assign sel_s   = pins_sync[2:0];
  assign oea_n_s = pins_sync[3];
  assign oeb_n_s = pins_sync[4];

  // ==========================================================================
  // Sample memory
  assign wr_set = {sample_i, sample_q, sample_magnitude, sample_phase,
                   sample_frequency};

  brf_sample_ram u_ram (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (do_wr),
    .wr_addr (st_r.wr_ptr),
    .wr_data (wr_set),
    .rd_addr (st_r.rd_ptr),
    .rd_data (set_data)
  );

  // ==========================================================================
  // Word selection for both read ports
  function automatic logic [15:0] word_of(
    input logic [2:0]  sel,
    input logic [79:0] set,
    input logic [15:0] status
  );
    logic [15:0] w;
    w = 16'h0000;
    case (sel)
      `BRF_SEL_I:      w = set[`BRF_I_LSB +: `BRF_WORD_W];
      `BRF_SEL_Q:      w = set[`BRF_Q_LSB +: `BRF_WORD_W];
      `BRF_SEL_MAG:    w = set[`BRF_MAG_LSB +: `BRF_WORD_W];
      `BRF_SEL_PHASE:  w = set[`BRF_PHASE_LSB +: `BRF_WORD_W];
      `BRF_SEL_FREQ:   w = set[`BRF_FREQ_LSB +: `BRF_WORD_W];
      `BRF_SEL_STATUS: w = status;
      default:         w = 16'h0000;
    endcase
    return w;
  endfunction : word_of

  // ==========================================================================
  // Pointer status
  always_comb begin
    depth = st_r.wr_ptr - st_r.rd_ptr;
    full  = (depth == `BRF_DEPTH_FULL);
    empty = (depth == `BRF_DEPTH_EMPTY);
  end

  // Memory status word, low A bits and B byte tied to zero
  always_comb begin
    status_word = 16'h0000;
    if (fifo_mode) begin
      status_word[8+`BRF_ST_DEPTH_MSB:8+`BRF_ST_DEPTH_LSB] = depth;
      status_word[8+`BRF_ST_EMPTY_BIT] = empty;
      status_word[8+`BRF_ST_FULL_BIT]  = full;
    end
    status_word[8+`BRF_ST_READY_BIT] = st_r.ready_n;
  end

  // ==========================================================================
  // Access requests
  always_comb begin
    oeb_fall = st_r.oeb_prev & ~oeb_n_s;
    inc_req  = 1'b0;
    if (port16_select) begin
      inc_req = oeb_fall & (sel_s == `BRF_SEL_INC);
    end else begin
      inc_req = pointer_increment_write;
    end
    do_inc = inc_req & ~empty & ~pointer_reset_write;
    do_wr  = sample_valid & ~full & ~pointer_reset_write;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt           = st_r;
    st_nxt.oeb_prev  = oeb_n_s;
    st_nxt.snap_prev = snapshot_done;

    // Pointer movement
    if (pointer_reset_write) begin
      st_nxt.wr_ptr = `BRF_WR_PTR_RST;
      st_nxt.rd_ptr = `BRF_RD_PTR_RST;
    end else begin
      if (do_wr) begin
        st_nxt.wr_ptr = st_r.wr_ptr + 3'h1;
      end
      if (do_inc) begin
        st_nxt.rd_ptr = st_r.rd_ptr + 3'h1;
      end
    end
    depth_after = st_nxt.wr_ptr - st_nxt.rd_ptr;

    // Threshold crossing
    above_now   = (depth > depth_threshold);
    above_after = (depth_after > depth_threshold);
    if (fifo_mode) begin
      irq_fire = above_after & ~above_now;
      st_nxt.ready_n = ~above_after;
    end else begin
      irq_fire = snapshot_done & ~st_r.snap_prev;
      st_nxt.ready_n = ~snapshot_done;
    end

    // Interrupt pulse, eight clocks low
    if (st_r.irq_cnt != 4'h0) begin
      st_nxt.irq_cnt = st_r.irq_cnt - 4'h1;
      if (st_r.irq_cnt == 4'h1) begin
        st_nxt.irq_n = 1'b1;
      end
    end else if (irq_fire) begin
      st_nxt.irq_cnt = `BRF_IRQ_LOW_CYCLES;
      st_nxt.irq_n   = 1'b0;
    end

    // 16-bit port: word latched on B enable fall only
    if (port16_select && oeb_fall) begin
      st_nxt.word = word_of(sel_s, set_data, status_word);
    end
    if (port16_select && !oea_n_s && !oeb_n_s) begin
      st_nxt.a_out = st_r.word[15:8];
      st_nxt.b_out = st_r.word[7:0];
    end else begin
      st_nxt.a_out = 8'h00;
      st_nxt.b_out = 8'h00;
    end

    // 8-bit port word
    if (!port16_select) begin
      st_nxt.cpu_data = word_of(cpu_read_select, set_data, status_word);
    end else begin
      st_nxt.cpu_data = 16'h0000;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.wr_ptr    <= `BRF_WR_PTR_RST;
      st_r.rd_ptr    <= `BRF_RD_PTR_RST;
      st_r.oeb_prev  <= 1'b1;
      st_r.snap_prev <= 1'b0;
      st_r.word      <= 16'h0000;
      st_r.a_out     <= 8'h00;
      st_r.b_out     <= 8'h00;
      st_r.irq_n     <= 1'b1;
      st_r.irq_cnt   <= 4'h0;
      st_r.ready_n   <= 1'b1;
      st_r.cpu_data  <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign a_output_byte         = st_r.a_out;
  assign b_output_byte         = st_r.b_out;
  assign cpu_read_data         = st_r.cpu_data;
  assign threshold_interrupt_n = st_r.irq_n;
  assign threshold_ready_n     = st_r.ready_n;
  assign write_pointer         = st_r.wr_ptr;
  assign read_pointer          = st_r.rd_ptr;
  assign buffer_depth          = st_r.wr_ptr - st_r.rd_ptr;

endmodule : brf_read_port

// ===== src/brf_sample_ram.sv
/*
  Eight-entry sample-set memory, 80 bits per entry.
  Assumes one write port and one registered read port on clk.
*/
module brf_sample_ram (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [79:0] wr_data,
  input  wire logic [2:0]  rd_addr,
  output logic      [79:0] rd_data
);

  logic [79:0] mem [8];
  brf_pkg::brf_ram_state_type st_r;
  brf_pkg::brf_ram_state_type st_nxt;

  // ========================================================================
  // Storage, no reset on the array itself
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    st_nxt.rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;

endmodule : brf_sample_ram

// ===== src/brf_sync.sv
/*
  Two-flop synchroniser for the five read-port pins.
  Assumes pins are asynchronous to clk; only stage two is read outside.
*/
module brf_sync (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [4:0] pin_in,
  output logic      [4:0] pin_sync
);

  brf_pkg::brf_sync_state_type st_r;
  brf_pkg::brf_sync_state_type st_nxt;

  // ========================================================================
  // Per-bit double flop
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_bit
      always_comb begin
        st_nxt.stage1[g] = pin_in[g];
        st_nxt.stage2[g] = st_r.stage1[g];
      end
    end
  endgenerate

  // Enables idle high
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{stage1: 5'h18, stage2: 5'h18};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.stage2;

endmodule : brf_sync
